// *** tim_pkg.sv ***
// Constants, register map and field layout for the terminal interrupt manager.
// Assumes a host port outside that turns serial host accesses into word strobes.
//
// Notes on behaviour
// - Events with enable bit clear are ignored entirely
// - Enabling later never recognises earlier events
// - Enabled hardware event logs and sets pending bit
// - Only events already enabled when occurring count
// - Output-enabled event asserts the low interrupt line
// - Not output-enabled events: pending and logged only
// - One interrupt line shared by all three triplets
// - Hardware triplet always; terminal triplets when enabled
// - Bits 15..3 hardware, bits 2..1 summaries, bit 0 reads zero
// - Bit 1 set while monitor pending nonzero
// - Bit 2 set while remote pending nonzero
// - Reading a pending register returns then clears it
// - Bits 15..9 count logged interrupts since read
// - Count passes 32, saturates at 127
// - Reading count register clears the count
// - Circular 64-word log held in RAM
// - Two words per interrupt, pointer steps two, wraps
// - Reset reads count zero, pointer at buffer start
// - Hardware address word zero except parity fail address
`default_nettype none

package tim_pkg;
	localparam logic [5:0] TIM_REG_HW_PEND = 6'h06;
	localparam logic [5:0] TIM_REG_MON_PEND = 6'h08;
	localparam logic [5:0] TIM_REG_RT_PEND = 6'h09;
	localparam logic [5:0] TIM_REG_COUNT_LOG = 6'h0a;
	localparam logic [5:0] TIM_REG_HW_EN = 6'h0f;
	localparam logic [5:0] TIM_REG_HW_OEN = 6'h13;
	localparam logic [15:0] TIM_LOG_BASE = 16'h0180;
	localparam logic [15:0] TIM_LOG_LAST = 16'h01bf;
	localparam int TIM_LOG_WORDS = 64;
	localparam logic [5:0] TIM_LOG_STEP = 6'h02;
	localparam logic [6:0] TIM_CNT_MAX = 7'h7f;
	localparam logic [6:0] TIM_CNT_ONE = 7'h01;
	localparam int TIM_CNT_LSB = 9;
	localparam int TIM_HW_LSB = 3;
	localparam int TIM_MON_BIT = 1;
	localparam int TIM_RT_BIT = 2;
	localparam int TIM_SPARE_BIT = 0;
	localparam int TIM_PARITY_BIT = 15;
	localparam logic [15:0] TIM_ZERO = 16'h0000;
	localparam logic [15:0] TIM_HW_EN_RST = 16'h0000;
	localparam logic [15:0] TIM_HW_OEN_RST = 16'h0000;
	typedef enum logic [1:0] {
		TIM_LOG_IDLE = 2'b00,
		TIM_LOG_IDENT = 2'b01,
		TIM_LOG_ADDR = 2'b10
	} tim_log_state_t;
endpackage : tim_pkg

`default_nettype wire

// *** tim_triplet.sv ***
// One enable / pending / output-enable triplet for a group of event sources.
// Assumes events arrive as one-cycle pulses on the device clock.
`default_nettype none

module tim_triplet (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic active_i,
	input wire logic [15:0] event_i,
	input wire logic [15:0] enable_i,
	input wire logic [15:0] out_enable_i,
	input wire logic clear_i,
	output logic [15:0] accepted_o,
	output logic [15:0] pending_o,
	output logic irq_want_o
);
	logic [15:0] pend_q;
	logic [15:0] pend_d;

	// Enable is sampled at the event itself, so nothing is remembered while disabled
	assign accepted_o = active_i ? (event_i & enable_i) : tim_pkg::TIM_ZERO;
	// A new event in the clearing cycle survives the read
	assign pend_d = (clear_i ? tim_pkg::TIM_ZERO : pend_q) | accepted_o;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= tim_pkg::TIM_ZERO;
		end else begin
			pend_q <= pend_d;
		end
	end

	assign pending_o = pend_q;
	assign irq_want_o = |(pend_q & out_enable_i);

	pend_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(active_i && |(event_i & enable_i) && !clear_i) |=> ((pend_q & $past(event_i & enable_i))
		== $past(event_i & enable_i))) else $error("accepted event not pending");
	ignore_dis_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(clear_i && !(|accepted_o)) |=> (pend_q == tim_pkg::TIM_ZERO))
		else $error("disabled event or stale bit left pending");
endmodule // tim_triplet

`default_nettype wire

// *** tim_manager.sv ***
// Interrupt manager top: three triplets, shared low interrupt line, log buffer.
// Assumes the host port supplies one-cycle read and write strobes with a word address.
`default_nettype none

module tim_manager (
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	input wire logic RT_ENABLED_I,
	input wire logic MON_ENABLED_I,
	input wire logic [15:3] HW_EVENT_I,
	input wire logic [15:0] PARITY_ADDR_I,
	input wire logic [15:0] RT_EVENT_I,
	input wire logic [15:0] RT_ENABLE_I,
	input wire logic [15:0] RT_OUT_ENABLE_I,
	input wire logic [15:0] RT_ADDR_I,
	input wire logic [15:0] MON_EVENT_I,
	input wire logic [15:0] MON_ENABLE_I,
	input wire logic [15:0] MON_OUT_ENABLE_I,
	input wire logic [15:0] MON_ADDR_I,
	input wire logic HOST_RD_I,
	input wire logic HOST_WR_I,
	input wire logic [5:0] HOST_ADDR_I,
	input wire logic [15:0] HOST_WDATA_I,
	input wire logic LOG_RD_I,
	input wire logic [5:0] LOG_RADDR_I,
	output logic [15:0] HOST_RDATA_O,
	output logic [15:0] LOG_RDATA_O,
	output logic HOST_IRQ_N_O
);
	logic [15:0] hw_en_q;
	logic [15:0] hw_oen_q;
	logic [15:0] hw_acc;
	logic [15:0] rt_acc;
	logic [15:0] mon_acc;
	logic [15:0] hw_pend;
	logic [15:0] rt_pend;
	logic [15:0] mon_pend;
	logic hw_irq;
	logic rt_irq;
	logic mon_irq;
	logic [15:0] hw_ev;
	logic [15:0] hw_view;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic irq_n_q;
	logic rd_hw;
	logic rd_rt;
	logic rd_mon;
	logic rd_cnt;
	logic [6:0] cnt_q;
	logic [5:0] ptr_q;
	logic [15:0] log_mem [tim_pkg::TIM_LOG_WORDS];
	logic [15:0] log_rd_q;
	logic any_log;
	logic [15:0] ident_w;
	logic [15:0] addr_w;

	assign rd_hw = HOST_RD_I && (HOST_ADDR_I == tim_pkg::TIM_REG_HW_PEND);
	assign rd_rt = HOST_RD_I && (HOST_ADDR_I == tim_pkg::TIM_REG_RT_PEND);
	assign rd_mon = HOST_RD_I && (HOST_ADDR_I == tim_pkg::TIM_REG_MON_PEND);
	assign rd_cnt = HOST_RD_I && (HOST_ADDR_I == tim_pkg::TIM_REG_COUNT_LOG);
	assign hw_ev = {HW_EVENT_I, 3'b000};

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			hw_en_q <= tim_pkg::TIM_HW_EN_RST;
			hw_oen_q <= tim_pkg::TIM_HW_OEN_RST;
		end else if (HOST_WR_I) begin
			if (HOST_ADDR_I == tim_pkg::TIM_REG_HW_EN) begin
				hw_en_q <= HOST_WDATA_I;
			end
			if (HOST_ADDR_I == tim_pkg::TIM_REG_HW_OEN) begin
				hw_oen_q <= HOST_WDATA_I;
			end
		end
	end

	tim_triplet u_hw (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.active_i(1'b1),
		.event_i(hw_ev),
		.enable_i(hw_en_q),
		.out_enable_i(hw_oen_q),
		.clear_i(rd_hw),
		.accepted_o(hw_acc),
		.pending_o(hw_pend),
		.irq_want_o(hw_irq)
	);

	tim_triplet u_rt (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.active_i(RT_ENABLED_I),
		.event_i(RT_EVENT_I),
		.enable_i(RT_ENABLE_I),
		.out_enable_i(RT_OUT_ENABLE_I),
		.clear_i(rd_rt),
		.accepted_o(rt_acc),
		.pending_o(rt_pend),
		.irq_want_o(rt_irq)
	);

	tim_triplet u_mon (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.active_i(MON_ENABLED_I),
		.event_i(MON_EVENT_I),
		.enable_i(MON_ENABLE_I),
		.out_enable_i(MON_OUT_ENABLE_I),
		.clear_i(rd_mon),
		.accepted_o(mon_acc),
		.pending_o(mon_pend),
		.irq_want_o(mon_irq)
	);

	// Summary bits are live views, so they stay true until the terminal register is read
	always_comb begin
		hw_view = hw_pend;
		hw_view[tim_pkg::TIM_MON_BIT] = |mon_pend;
		hw_view[tim_pkg::TIM_RT_BIT] = |rt_pend;
		hw_view[tim_pkg::TIM_SPARE_BIT] = 1'b0;
	end

	always_comb begin
		rdata_d = tim_pkg::TIM_ZERO;
		case (HOST_ADDR_I)
			tim_pkg::TIM_REG_HW_PEND: rdata_d = hw_view;
			tim_pkg::TIM_REG_MON_PEND: rdata_d = mon_pend;
			tim_pkg::TIM_REG_RT_PEND: rdata_d = rt_pend;
			tim_pkg::TIM_REG_COUNT_LOG:
				rdata_d = {cnt_q, tim_pkg::TIM_LOG_BASE[8:6], ptr_q};
			tim_pkg::TIM_REG_HW_EN: rdata_d = hw_en_q;
			tim_pkg::TIM_REG_HW_OEN: rdata_d = hw_oen_q;
			default: rdata_d = tim_pkg::TIM_ZERO;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rdata_q <= tim_pkg::TIM_ZERO;
		end else if (HOST_RD_I) begin
			rdata_q <= rdata_d;
		end
	end

	// Registered line: one cycle behind the pending state it reflects
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= !(hw_irq || rt_irq || mon_irq);
		end
	end

	// Log entry: one group per cycle; hardware wins, then remote, then monitor.
	// Simultaneous events of different groups in one cycle log only the winner.
	assign any_log = |{hw_acc, rt_acc, mon_acc};
	always_comb begin
		ident_w = tim_pkg::TIM_ZERO;
		addr_w = tim_pkg::TIM_ZERO;
		if (|hw_acc) begin
			ident_w = hw_acc;
			if (hw_acc[tim_pkg::TIM_PARITY_BIT]) begin
				addr_w = PARITY_ADDR_I;
			end
		end else if (|rt_acc) begin
			ident_w = {rt_acc[15:3], 3'b000};
			ident_w[tim_pkg::TIM_RT_BIT] = 1'b1;
			addr_w = RT_ADDR_I;
		end else if (|mon_acc) begin
			ident_w = {mon_acc[15:3], 3'b000};
			ident_w[tim_pkg::TIM_MON_BIT] = 1'b1;
			addr_w = MON_ADDR_I;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ptr_q <= tim_pkg::TIM_LOG_BASE[5:0];
		end else if (any_log) begin
			ptr_q <= ptr_q + tim_pkg::TIM_LOG_STEP;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cnt_q <= '0;
		end else if (rd_cnt) begin
			cnt_q <= any_log ? tim_pkg::TIM_CNT_ONE : '0;
		end else if (any_log && cnt_q != tim_pkg::TIM_CNT_MAX) begin
			cnt_q <= cnt_q + tim_pkg::TIM_CNT_ONE;
		end
	end

	// Log words are a plain array, never reset; software reads them via the log port
	always_ff @(posedge REF_CLK_I) begin
		if (any_log) begin
			log_mem[ptr_q] <= ident_w;
			log_mem[ptr_q | 6'h01] <= addr_w;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			log_rd_q <= tim_pkg::TIM_ZERO;
		end else if (LOG_RD_I) begin
			log_rd_q <= log_mem[LOG_RADDR_I];
		end
	end

	assign HOST_RDATA_O = rdata_q;
	assign LOG_RDATA_O = log_rd_q;
	assign HOST_IRQ_N_O = irq_n_q;
	irq_follow_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(hw_irq || rt_irq || mon_irq) |=> !HOST_IRQ_N_O) else $error("line not asserted");
	irq_release_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!(hw_irq || rt_irq || mon_irq) |=> HOST_IRQ_N_O) else $error("line not released");
	low_prio_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		((hw_pend & hw_oen_q) == '0 && !rt_irq && !mon_irq) |=> HOST_IRQ_N_O)
		else $error("low priority drove line");
	rt_summary_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		hw_view[tim_pkg::TIM_RT_BIT] == (rt_pend != '0)) else $error("rt summary wrong");
	mon_summary_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		hw_view[tim_pkg::TIM_MON_BIT] == (mon_pend != '0)) else $error("mon summary wrong");
	ptr_step_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		any_log |=> ptr_q == $past(ptr_q) + tim_pkg::TIM_LOG_STEP) else $error("pointer step");
	ptr_even_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!ptr_q[0]) else $error("pointer odd");
	cnt_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(rd_cnt && !any_log) |=> cnt_q == '0) else $error("count not cleared");
	cnt_sat_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(cnt_q == tim_pkg::TIM_CNT_MAX && !rd_cnt) |=> cnt_q == tim_pkg::TIM_CNT_MAX)
		else $error("count wrapped");
	rt_gate_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!RT_ENABLED_I |-> rt_acc == '0) else $error("rt triplet active while off");
endmodule // tim_manager

`default_nettype wire

// *** tim_host_model.sv ***
// Host processor model: register reads and writes, log buffer reads.
// Assumes strobes are taken on the rising edge and data lands one edge later.
`default_nettype none

module tim_host_model (
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	input wire logic [15:0] log_rdata_i,
	output logic rd_o,
	output logic wr_o,
	output logic [5:0] addr_o,
	output logic [15:0] wdata_o,
	output logic log_rd_o,
	output logic [5:0] log_raddr_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 6'h00;
		wdata_o = 16'h0000;
		log_rd_o = 1'b0;
		log_raddr_o = 6'h00;
	end

	// Reads clear pending words, so callers keep what they read
	// Released address and data show the inverse, never the stale value
	task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
		output logic [15:0] q);
		addr_o = a;
		wdata_o = d;
		rd_o = ~w;
		wr_o = w;
		@(negedge clk_i);
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
		@(negedge clk_i);
		q = rdata_i;
	endtask

	task automatic log_rd(input logic [5:0] a, output logic [15:0] q);
		log_raddr_o = a;
		log_rd_o = 1'b1;
		@(negedge clk_i);
		log_rd_o = 1'b0;
		log_raddr_o = ~a;
		@(negedge clk_i);
		q = log_rdata_i;
	endtask
endmodule // tim_host_model

`default_nettype wire

// *** tim_manager_bench.sv ***
// Self-checking bench for the interrupt manager with a host model.
// Assumes inputs change at falling edges and the host model owns the host port.
`default_nettype none

module tim_manager_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rt_on = 1'b0;
	logic mon_on = 1'b0;
	logic [15:3] hw_ev = '0;
	logic [15:0] par_addr = 16'h0000;
	logic [15:0] rt_ev = 16'h0000;
	logic [15:0] rt_en = 16'h0000;
	logic [15:0] rt_oen = 16'h0000;
	logic [15:0] mon_ev = 16'h0000;
	logic [15:0] mon_en = 16'h0000;
	logic [15:0] mon_oen = 16'h0000;
	logic [15:0] rt_addr = 16'h0abc;
	logic [15:0] mon_addr = 16'h0def;
	logic rd, wr, lrd, irq_n;
	logic [5:0] addr, laddr;
	logic [15:0] wdata, rdata, ldata, p;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;

	always #2 clk = ~clk;

	tim_host_model tim_host_model_inst (.clk_i(clk), .rdata_i(rdata), .log_rdata_i(ldata),
		.rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata), .log_rd_o(lrd),
		.log_raddr_o(laddr));

	tim_manager tim_manager_inst (.REF_CLK_I(clk), .RESETN_I(rstn), .RT_ENABLED_I(rt_on),
		.MON_ENABLED_I(mon_on), .HW_EVENT_I(hw_ev), .PARITY_ADDR_I(par_addr),
		.RT_EVENT_I(rt_ev), .RT_ENABLE_I(rt_en), .RT_OUT_ENABLE_I(rt_oen),
		.RT_ADDR_I(rt_addr), .MON_EVENT_I(mon_ev), .MON_ENABLE_I(mon_en),
		.MON_OUT_ENABLE_I(mon_oen), .MON_ADDR_I(mon_addr), .HOST_RD_I(rd),
		.HOST_WR_I(wr), .HOST_ADDR_I(addr), .HOST_WDATA_I(wdata), .LOG_RD_I(lrd),
		.LOG_RADDR_I(laddr), .HOST_RDATA_O(rdata), .LOG_RDATA_O(ldata),
		.HOST_IRQ_N_O(irq_n));

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd_reg(input logic [5:0] a, output logic [15:0] q);
		tim_host_model_inst.xfer(1'b0, a, 16'h0000, q);
	endtask

	task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] q;
		tim_host_model_inst.xfer(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
		logic [15:0] q;
		rd_reg(a, q);
		chk(q, exp);
	endtask

	task automatic lrdc(input logic [5:0] a, input logic [15:0] exp);
		logic [15:0] q;
		tim_host_model_inst.log_rd(a, q);
		chk(q, exp);
	endtask

	// One-cycle pulse, then wait until the registered line has settled
	task automatic ev(input logic [15:0] h, input logic [15:0] r, input logic [15:0] m);
		hw_ev = h[15:3];
		rt_ev = r;
		mon_ev = m;
		@(negedge clk);
		hw_ev = '0;
		rt_ev = 16'h0000;
		mon_ev = 16'h0000;
		repeat (2) @(negedge clk);
	endtask

	task automatic t_reset;
		rdc(6'h0a, 16'h0180);
		rdc(6'h0f, 16'h0000);
		wr_reg(6'h01, 16'hffff);
		rdc(6'h01, 16'h0000);
		chk({15'h0000, irq_n}, 16'h0001);
	endtask

	task automatic t_hw;
		ev(16'h0020, 16'h0000, 16'h0000);
		rdc(6'h06, 16'h0000);
		wr_reg(6'h0f, 16'h0020);
		rdc(6'h06, 16'h0000);
		rdc(6'h0a, 16'h0180);
		wr_reg(6'h13, 16'h0020);
		ev(16'h0020, 16'h0000, 16'h0000);
		chk({15'h0000, irq_n}, 16'h0000);
		rdc(6'h06, 16'h0020);
		rdc(6'h06, 16'h0000);
		chk({15'h0000, irq_n}, 16'h0001);
		rdc(6'h0a, 16'h0382);
		rdc(6'h0a, 16'h0182);
		lrdc(6'h00, 16'h0020);
		lrdc(6'h01, 16'h0000);
		wr_reg(6'h0f, 16'h0060);
		ev(16'h0040, 16'h0000, 16'h0000);
		chk({15'h0000, irq_n}, 16'h0001);
		rdc(6'h06, 16'h0040);
	endtask

	task automatic t_term;
		rt_en = 16'h0010;
		rt_oen = 16'h0010;
		ev(16'h0000, 16'h0010, 16'h0000);
		rdc(6'h09, 16'h0000);
		rdc(6'h06, 16'h0000);
		rt_on = 1'b1;
		mon_on = 1'b1;
		mon_en = 16'h0008;
		ev(16'h0000, 16'h0010, 16'h0000);
		chk({15'h0000, irq_n}, 16'h0000);
		rdc(6'h06, 16'h0004);
		rdc(6'h09, 16'h0010);
		ev(16'h0000, 16'h0000, 16'h0008);
		rdc(6'h06, 16'h0002);
		ev(16'h0000, 16'h0010, 16'h0000);
		rdc(6'h06, 16'h0006);
		rdc(6'h09, 16'h0010);
		rdc(6'h08, 16'h0008);
		rdc(6'h06, 16'h0000);
		chk({15'h0000, irq_n}, 16'h0001);
		lrdc(6'h04, 16'h0014);
		lrdc(6'h05, 16'h0abc);
		lrdc(6'h06, 16'h000a);
		lrdc(6'h07, 16'h0def);
	endtask

	task automatic t_parity;
		wr_reg(6'h0f, 16'h8000);
		rd_reg(6'h0a, p);
		par_addr = 16'h1234;
		ev(16'h8000, 16'h0000, 16'h0000);
		lrdc(p[5:0], 16'h8000);
		lrdc(p[5:0] + 6'h01, 16'h1234);
	endtask

	// 130 logged events overrun the 32-entry log and saturate the count
	task automatic t_sat;
		wr_reg(6'h0f, 16'h0020);
		rd_reg(6'h0a, p);
		repeat (130) ev(16'h0020, 16'h0000, 16'h0000);
		rdc(6'h0a, {7'h7f, 3'b110, p[5:0] + 6'h04});
	endtask

	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		t_reset();
		t_hw();
		t_term();
		t_parity();
		t_sat();
		close_out();
	end
endmodule // tim_manager_bench

`default_nettype wire
